// ==== design/srd_addr_len.sv ====
// Purpose: Length of the addressing bytes after the mod byte
// Assumes: Sib byte is only meaningful when need_sib was seen
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
`include "srd_defines.svh"

module srd_addr_len #(
	parameter int ADDR32 = 1
) (
	input wire logic [7:0] modrm,
	input wire logic [7:0] sib,
	output logic need_sib,
	output logic [2:0] disp_len
);

	logic [1:0] md;
	logic [2:0] rm;

	if (ADDR32 < 0 || ADDR32 > 1) begin : g_chk
		$error("ADDR32 must be 0 or 1");
	end

	assign md = modrm[7:6];
	assign rm = modrm[2:0];

	always_comb begin
		need_sib = 1'b0;
		disp_len = `SRD_DISP_0;
		if (md != `SRD_MOD_REG) begin
			if (ADDR32 == 1) begin
				need_sib = (rm == `SRD_RM_SIB);
				if (md == 2'h1) begin
					disp_len = `SRD_DISP_1;
				end else if (md == 2'h2) begin
					disp_len = `SRD_DISP_4;
				end else if (rm == `SRD_RM_D32) begin
					disp_len = `SRD_DISP_4;
				end else if (rm == `SRD_RM_SIB && sib[2:0] == `SRD_RM_D32) begin
					disp_len = `SRD_DISP_4;
				end
			end else begin
				if (md == 2'h1) begin
					disp_len = `SRD_DISP_1;
				end else if (md == 2'h2) begin
					disp_len = `SRD_DISP_2;
				end else if (rm == `SRD_RM_D16) begin
					disp_len = `SRD_DISP_2;
				end
			end
		end
	end

endmodule : srd_addr_len
`default_nettype wire

// ==== design/srd_decoder.sv ====
// Purpose: Decode and time shift, rotate, double shift and AND forms
// Assumes: Queue bytes synchronous to CLK_SYS
// Notes: One instruction at a time, held until taken
// Behaviour
// - D0/D1 is a shift or rotate by one, select field picks it
// - D2/D3 is a shift or rotate counted by the count byte register
// - C0/C1 is a shift or rotate by a trailing immediate byte
// - Select field maps 000..111 except 110 (undefined) to the seven shift and rotate ops
// - Plain shifts and rotates take 3 clocks register, 7 memory
// - Rotates through carry take 9 clocks register, 10 memory
// - Carry rotate by one shares the opcode; select 010 or 011
// - 0F A4 is double left shift with immediate count byte
// - 0F A5 is double left shift counted by count byte register
// - 0F AC immediate and 0F AD register count are double right shifts
// - Double shifts take 3 clocks register, 7 memory
// - 001000dw register to register AND takes 2 clocks
`timescale 1ns/1ps
`default_nettype none
`include "srd_defines.svh"

module srd_decoder
	import srd_pkg::*;
#(
	parameter int ADDR32 = 1
) (
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	output logic BYTE_READY,
	output logic DEC_VALID,
	input wire logic DEC_READY,
	output srd_pkg::srd_op_e DEC_OP,
	output srd_pkg::srd_cnt_e DEC_COUNT_SRC,
	output logic DEC_WIDE,
	output logic DEC_REG_IS_DEST,
	output logic DEC_MEM,
	output logic [2:0] DEC_REG_FIELD,
	output logic [2:0] DEC_RM_FIELD,
	output logic [31:0] DEC_DISP,
	output logic [7:0] DEC_IMM,
	output logic [4:0] DEC_CLOCKS,
	output logic DEC_UNDEF
);
	import srd_pkg::*;

	localparam srd_regs_s RESET_VAL = '{
		state: ST_OPC, grp: grp_none, op: foreign_op, cnt: cnt_none,
		default: '0
	};

	srd_regs_s r_reg;
	srd_regs_s r_next;
	logic take;
	logic need_sib;
	logic [2:0] alen;
	logic [7:0] len_modrm;

	if (ADDR32 < 0 || ADDR32 > 1) begin : g_chk
		$error("ADDR32 must be 0 or 1");
	end

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [4:0] srd_clocks(srd_op_e op, logic mem);
		unique case (op)
			rotate_left_op, rotate_right_op, shift_left_op,
			logical_right_op, arith_right_op,
			double_left_shift_op, double_right_shift_op:
				srd_clocks = mem ? `SRD_CLK_PLAIN_MEM : `SRD_CLK_PLAIN_REG;
			rotate_left_carry_op, rotate_right_carry_op:
				srd_clocks = mem ? `SRD_CLK_CARRY_MEM : `SRD_CLK_CARRY_REG;
			and_op:
				srd_clocks = `SRD_CLK_AND_REG;
			default:
				srd_clocks = `SRD_CLK_NONE;
		endcase
	endfunction : srd_clocks

	function automatic srd_state_e srd_after(logic [2:0] dl, logic ni);
		if (dl != `SRD_DISP_0) begin
			srd_after = ST_DISP;
		end else if (ni) begin
			srd_after = ST_IMM;
		end else begin
			srd_after = ST_DONE;
		end
	endfunction : srd_after

	////////////////////////////////////////////////////////////////////
	// Addressing length

	assign len_modrm = (r_reg.state == ST_SIB) ? r_reg.modrm : BYTE_DATA;

	srd_addr_len #(.ADDR32(ADDR32)) u_len (
		.modrm(len_modrm),
		.sib(BYTE_DATA),
		.need_sib(need_sib),
		.disp_len(alen)
	);

	////////////////////////////////////////////////////////////////////
	// Next state

	assign BYTE_READY = (r_reg.state != ST_DONE);
	assign take = BYTE_VALID && BYTE_READY;

	always_comb begin
		r_next = r_reg;
		unique case (r_reg.state)
			ST_OPC: if (take) begin
				r_next = RESET_VAL;
				r_next.wide = BYTE_DATA[`SRD_W_BIT];
				r_next.grp = grp_shift;
				r_next.state = ST_MODRM;
				if ((BYTE_DATA & `SRD_MASK_W) == `SRD_OPC_BY1) begin
					r_next.cnt = cnt_one;
				end else if ((BYTE_DATA & `SRD_MASK_W) == `SRD_OPC_BYC) begin
					r_next.cnt = count_byte_register;
				end else if ((BYTE_DATA & `SRD_MASK_W) == `SRD_OPC_BYI) begin
					r_next.cnt = cnt_imm;
					r_next.need_imm = 1'b1;
				end else if (BYTE_DATA == `SRD_OPC_ESC) begin
					r_next.grp = grp_double;
					r_next.state = ST_ESC;
				end else if ((BYTE_DATA & `SRD_MASK_DW) == `SRD_OPC_AND) begin
					r_next.grp = grp_and;
					r_next.op = and_op;
					r_next.dir = BYTE_DATA[`SRD_D_BIT];
				end else begin
					r_next.grp = grp_none;
					r_next.state = ST_DONE;
				end
			end
			ST_ESC: if (take) begin
				r_next.wide = 1'b1;
				r_next.state = ST_MODRM;
				if (BYTE_DATA == `SRD_OPC_DLI) begin
					r_next.op = double_left_shift_op;
					r_next.cnt = cnt_imm;
					r_next.need_imm = 1'b1;
				end else if (BYTE_DATA == `SRD_OPC_DLC) begin
					r_next.op = double_left_shift_op;
					r_next.cnt = count_byte_register;
				end else if (BYTE_DATA == `SRD_OPC_DRI) begin
					r_next.op = double_right_shift_op;
					r_next.cnt = cnt_imm;
					r_next.need_imm = 1'b1;
				end else if (BYTE_DATA == `SRD_OPC_DRC) begin
					r_next.op = double_right_shift_op;
					r_next.cnt = count_byte_register;
				end else begin
					r_next.grp = grp_none;
					r_next.state = ST_DONE;
				end
			end
			ST_MODRM: if (take) begin
				r_next.modrm = BYTE_DATA;
				r_next.reg_f = BYTE_DATA[5:3];
				r_next.rm_f = BYTE_DATA[2:0];
				r_next.mem = (BYTE_DATA[7:6] != `SRD_MOD_REG);
				if (r_reg.grp == grp_shift) begin
					if (BYTE_DATA[5:3] == `SRD_TTT_BAD) begin
						r_next.op = undef_op;
						r_next.undef = 1'b1;
					end else begin
						r_next.op = srd_op_e'({1'b0, BYTE_DATA[5:3]});
					end
				end
				r_next.clocks = srd_clocks(r_next.op, r_next.mem);
				r_next.dlen = alen;
				if (r_reg.grp == grp_and && r_next.mem) begin
					r_next.op = foreign_op;
					r_next.clocks = `SRD_CLK_NONE;
					r_next.state = ST_DONE;
				end else if (need_sib) begin
					r_next.state = ST_SIB;
				end else begin
					r_next.state = srd_after(alen, r_reg.need_imm);
				end
			end
			ST_SIB: if (take) begin
				r_next.dlen = alen;
				r_next.state = srd_after(alen, r_reg.need_imm);
			end
			ST_DISP: if (take) begin
				r_next.disp[{r_reg.didx, 3'h0} +: 8] = BYTE_DATA;
				r_next.didx = r_reg.didx + 2'h1;
				if (({1'b0, r_reg.didx} + 3'h1) == r_reg.dlen) begin
					r_next.state = r_reg.need_imm ? ST_IMM : ST_DONE;
				end
			end
			ST_IMM: if (take) begin
				r_next.imm = BYTE_DATA;
				r_next.state = ST_DONE;
			end
			ST_DONE: if (DEC_READY) begin
				r_next.state = ST_OPC;
			end
			default: r_next.state = ST_OPC;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			r_reg <= RESET_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign DEC_VALID = (r_reg.state == ST_DONE);
	assign DEC_OP = r_reg.op;
	assign DEC_COUNT_SRC = r_reg.cnt;
	assign DEC_WIDE = r_reg.wide;
	assign DEC_REG_IS_DEST = r_reg.dir;
	assign DEC_MEM = r_reg.mem;
	assign DEC_REG_FIELD = r_reg.reg_f;
	assign DEC_RM_FIELD = r_reg.rm_f;
	assign DEC_DISP = r_reg.disp;
	assign DEC_IMM = r_reg.imm;
	assign DEC_CLOCKS = r_reg.clocks;
	assign DEC_UNDEF = r_reg.undef;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	sequence s_opc(logic [7:0] m, logic [7:0] v);
		take && r_reg.state == ST_OPC && ((BYTE_DATA & m) == v);
	endsequence
	sequence s_esc(logic [7:0] v);
		take && r_reg.state == ST_ESC && BYTE_DATA == v;
	endsequence
	sequence s_ttt(logic [2:0] v);
		take && r_reg.state == ST_MODRM && r_reg.grp == grp_shift &&
			BYTE_DATA[5:3] == v;
	endsequence

	a_by_one_count: assert property (s_opc(`SRD_MASK_W, `SRD_OPC_BY1) |=>
		r_reg.cnt == cnt_one && r_reg.state == ST_MODRM)
		else $error("by-one opcode not decoded");
	a_by_reg_count: assert property (s_opc(`SRD_MASK_W, `SRD_OPC_BYC) |=>
		r_reg.cnt == count_byte_register && r_reg.state == ST_MODRM)
		else $error("count register opcode not decoded");
	a_imm_count: assert property (s_opc(`SRD_MASK_W, `SRD_OPC_BYI) |=>
		r_reg.cnt == cnt_imm && r_reg.need_imm)
		else $error("immediate count opcode not decoded");
	a_imm_capture: assert property (take && r_reg.state == ST_IMM |=>
		DEC_VALID && DEC_IMM == $past(BYTE_DATA))
		else $error("immediate byte not captured");
	a_ttt_rotl: assert property (s_ttt(`SRD_TTT_ROL) |=>
		r_reg.op == rotate_left_op)
		else $error("select 000 not rotate left");
	a_ttt_sar: assert property (s_ttt(`SRD_TTT_SAR) |=>
		r_reg.op == arith_right_op)
		else $error("select 111 not arithmetic right");
	a_carry_sel: assert property (s_ttt(`SRD_TTT_RCL) or s_ttt(`SRD_TTT_RCR)
		|=> r_reg.op inside {rotate_left_carry_op, rotate_right_carry_op} &&
		r_reg.op[0] == $past(BYTE_DATA[3]))
		else $error("carry rotate select lost");
	a_plain_clocks: assert property (DEC_VALID && DEC_OP inside
		{rotate_left_op, rotate_right_op, shift_left_op, logical_right_op,
		arith_right_op} |-> DEC_CLOCKS == (DEC_MEM ? 5'h07 : 5'h03))
		else $error("plain shift clock count wrong");
	a_carry_clocks: assert property (DEC_VALID && DEC_OP inside
		{rotate_left_carry_op, rotate_right_carry_op} |->
		DEC_CLOCKS == (DEC_MEM ? 5'h0A : 5'h09))
		else $error("carry rotate clock count wrong");
	a_dbl_left_imm: assert property (s_esc(`SRD_OPC_DLI) |=>
		r_reg.op == double_left_shift_op && r_reg.need_imm)
		else $error("double left immediate not decoded");
	a_dbl_left_reg: assert property (s_esc(`SRD_OPC_DLC) |=>
		r_reg.op == double_left_shift_op && r_reg.cnt == count_byte_register)
		else $error("double left register not decoded");
	a_dbl_right: assert property (s_esc(`SRD_OPC_DRI) or s_esc(`SRD_OPC_DRC)
		|=> r_reg.op == double_right_shift_op)
		else $error("double right not decoded");
	a_dbl_clocks: assert property (DEC_VALID && DEC_OP inside
		{double_left_shift_op, double_right_shift_op} |->
		DEC_CLOCKS == (DEC_MEM ? 5'h07 : 5'h03))
		else $error("double shift clock count wrong");
	a_and_regs: assert property (DEC_VALID && DEC_OP == and_op |->
		!DEC_MEM && DEC_CLOCKS == 5'h02)
		else $error("register AND wrong");
	a_width_bit: assert property (s_opc(`SRD_MASK_W, `SRD_OPC_BY1) |=>
		r_reg.wide == $past(BYTE_DATA[0]))
		else $error("width bit not kept");
	a_undef_sel: assert property (s_ttt(`SRD_TTT_BAD) |=>
		r_reg.undef && r_reg.op == undef_op)
		else $error("select 110 not undefined");
	a_hold_out: assert property (DEC_VALID && !DEC_READY |=>
		DEC_VALID && $stable(DEC_CLOCKS) && $stable(DEC_OP))
		else $error("result changed while held");

endmodule : srd_decoder
`default_nettype wire

// ==== design/srd_defines.svh ====
// Purpose: Constants for the shift and rotate decoder
// Assumes: Opcode bytes arrive one at a time from the queue
// Notes: Clock counts are core clocks
`ifndef SRD_DEFINES_SVH
`define SRD_DEFINES_SVH

// Opcode masks and values
`define SRD_MASK_W 8'hFE
`define SRD_MASK_DW 8'hFC
`define SRD_MASK_ALL 8'hFF
`define SRD_OPC_BY1 8'hD0
`define SRD_OPC_BYC 8'hD2
`define SRD_OPC_BYI 8'hC0
`define SRD_OPC_ESC 8'h0F
`define SRD_OPC_AND 8'h20
`define SRD_OPC_DLI 8'hA4
`define SRD_OPC_DLC 8'hA5
`define SRD_OPC_DRI 8'hAC
`define SRD_OPC_DRC 8'hAD

// Field positions
`define SRD_W_BIT 0
`define SRD_D_BIT 1
`define SRD_MOD_REG 2'h3
`define SRD_RM_SIB 3'h4
`define SRD_RM_D32 3'h5
`define SRD_RM_D16 3'h6

// Operation select codes
`define SRD_TTT_ROL 3'h0
`define SRD_TTT_RCL 3'h2
`define SRD_TTT_RCR 3'h3
`define SRD_TTT_BAD 3'h6
`define SRD_TTT_SAR 3'h7

// Clock counts
`define SRD_CLK_PLAIN_REG 5'h03
`define SRD_CLK_PLAIN_MEM 5'h07
`define SRD_CLK_CARRY_REG 5'h09
`define SRD_CLK_CARRY_MEM 5'h0A
`define SRD_CLK_AND_REG 5'h02
`define SRD_CLK_NONE 5'h00

// Displacement lengths
`define SRD_DISP_0 3'h0
`define SRD_DISP_1 3'h1
`define SRD_DISP_2 3'h2
`define SRD_DISP_4 3'h4

`endif

// ==== design/srd_pkg.sv ====
// Purpose: Types for the shift and rotate decoder
// Assumes: Nothing beyond the defines header
// Notes: Shift ops use the operation select code as their value
package srd_pkg;

	typedef enum logic [2:0] {
		ST_OPC = 3'h0,
		ST_ESC = 3'h1,
		ST_MODRM = 3'h2,
		ST_SIB = 3'h3,
		ST_DISP = 3'h4,
		ST_IMM = 3'h5,
		ST_DONE = 3'h6
	} srd_state_e;

	typedef enum logic [3:0] {
		rotate_left_op = 4'h0,
		rotate_right_op = 4'h1,
		rotate_left_carry_op = 4'h2,
		rotate_right_carry_op = 4'h3,
		shift_left_op = 4'h4,
		logical_right_op = 4'h5,
		undef_op = 4'h6,
		arith_right_op = 4'h7,
		double_left_shift_op = 4'h8,
		double_right_shift_op = 4'h9,
		and_op = 4'hA,
		foreign_op = 4'hF
	} srd_op_e;

	// Same encoding as the plain left shift
	localparam srd_op_e arith_left_op = shift_left_op;

	typedef enum logic [1:0] {
		cnt_none = 2'h0,
		cnt_one = 2'h1,
		count_byte_register = 2'h2,
		cnt_imm = 2'h3
	} srd_cnt_e;

	typedef enum logic [1:0] {
		grp_none = 2'h0,
		grp_shift = 2'h1,
		grp_double = 2'h2,
		grp_and = 2'h3
	} srd_grp_e;

	typedef struct packed {
		srd_state_e state;
		srd_grp_e grp;
		srd_op_e op;
		srd_cnt_e cnt;
		logic wide;
		logic dir;
		logic mem;
		logic [2:0] reg_f;
		logic [2:0] rm_f;
		logic [7:0] modrm;
		logic [31:0] disp;
		logic [1:0] didx;
		logic [2:0] dlen;
		logic need_imm;
		logic [7:0] imm;
		logic [4:0] clocks;
		logic undef;
	} srd_regs_s;

endpackage : srd_pkg

// ==== tb/srd_decoder_tb.sv ====
// Purpose: Self-checking bench for the shift and rotate decoder
// Assumes: 32-bit addressing, SIB base 101 when select bit 0 set
// Notes: Random forms and stalls from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module srd_decoder_tb;
	import srd_pkg::*;

	typedef struct packed {
		srd_op_e op;
		srd_cnt_e cnt;
		logic wide;
		logic dest;
		logic mem;
		logic [5:0] rr;
		logic [31:0] disp;
		logic [7:0] imm;
		logic [4:0] clocks;
		logic undef;
		logic full;
	} srd_exp_s;

	logic CLK_SYS, SYS_RST, gap, stall, BYTE_VALID, BYTE_READY, DEC_READY;
	logic [7:0] BYTE_DATA;
	logic DEC_VALID, DEC_WIDE, DEC_REG_IS_DEST, DEC_MEM, DEC_UNDEF;
	srd_op_e DEC_OP;
	srd_cnt_e DEC_COUNT_SRC;
	logic [2:0] DEC_REG_FIELD, DEC_RM_FIELD;
	logic [31:0] DEC_DISP;
	logic [7:0] DEC_IMM;
	logic [4:0] DEC_CLOCKS;
	int seed = 32'h931a3d54;
	int miscompares = 0;
	int check_count = 0;
	int i;
	srd_exp_s expq[$];
	srd_exp_s cur;

	srd_decoder #(.ADDR32(1)) DUT (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
		.BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
		.BYTE_READY(BYTE_READY), .DEC_VALID(DEC_VALID),
		.DEC_READY(DEC_READY), .DEC_OP(DEC_OP),
		.DEC_COUNT_SRC(DEC_COUNT_SRC), .DEC_WIDE(DEC_WIDE),
		.DEC_REG_IS_DEST(DEC_REG_IS_DEST), .DEC_MEM(DEC_MEM),
		.DEC_REG_FIELD(DEC_REG_FIELD), .DEC_RM_FIELD(DEC_RM_FIELD),
		.DEC_DISP(DEC_DISP), .DEC_IMM(DEC_IMM), .DEC_CLOCKS(DEC_CLOCKS),
		.DEC_UNDEF(DEC_UNDEF));

	srd_queue_model u_queue (.clk(CLK_SYS), .gap(gap), .stall(stall),
		.byte_ready(BYTE_READY), .byte_valid(BYTE_VALID),
		.byte_data(BYTE_DATA), .dec_ready(DEC_READY));

	initial CLK_SYS = 1'b0;
	always #12.5 CLK_SYS = ~CLK_SYS;

	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////
	// Expected clocks of a shift, rotate or double shift
	function automatic logic [4:0] exp_clocks(input logic carry,
		input logic mem);
		if (carry)
			return mem ? 5'h0A : 5'h09;
		return mem ? 5'h07 : 5'h03;
	endfunction : exp_clocks

	////////////////////////////////////////////////////////////////////
	// Forms 0-2 shifts, 3-6 double shifts, 7 AND, 8 foreign
	task automatic gen(input int form, input logic [7:0] mb);
		srd_exp_s e;
		logic [7:0] b;
		int n;
		b = 8'($random(seed));
		e = '0;
		e.full = 1'b1;
		e.mem = mb[7:6] != 2'h3;
		e.rr = mb[5:0];
		e.wide = b[0];
		if (form < 3) begin
			u_queue.put_byte(form == 2 ? {7'h60, b[0]} : {7'h68 | 7'(form), b[0]});
			e.op = srd_op_e'({1'b0, mb[5:3]});
			e.cnt = form == 0 ? cnt_one : form == 1 ? count_byte_register : cnt_imm;
			e.undef = mb[5:3] == 3'h6;
			e.clocks = e.undef ? 5'h00 : exp_clocks(mb[5:4] == 2'h1, e.mem);
		end else if (form < 7) begin
			u_queue.put_byte(8'h0F);
			u_queue.put_byte(form < 5 ? 8'hA1 + 8'(form) : 8'hA7 + 8'(form));
			e.wide = 1'b1;
			e.op = form < 5 ? double_left_shift_op : double_right_shift_op;
			e.cnt = form[0] ? cnt_imm : count_byte_register;
			e.clocks = exp_clocks(1'b0, e.mem);
		end else if (form == 7) begin
			u_queue.put_byte({6'h08, b[1:0]});
			e.dest = b[1];
			e.op = e.mem ? foreign_op : and_op;
			e.clocks = e.mem ? 5'h00 : 5'h02;
			e.full = !e.mem;
		end else begin
			u_queue.put_byte(8'h90);
			e.op = foreign_op;
			e.full = 1'b0;
		end
		if (form < 8)
			u_queue.put_byte(mb);
		if (form < 7 && e.mem) begin
			if (mb[2:0] == 3'h4)
				u_queue.put_byte({b[7:3], mb[3] ? 3'h5 : 3'h0});
			n = mb[7:6] == 2'h1 ? 1 : mb[7:6] == 2'h2 ? 4 : 0;
			if (mb[7:6] == 2'h0 && (mb[2:0] == 3'h5 || mb[3:0] == 4'hC))
				n = 4;
			for (int k = 0; k < n; k++) begin
				b = 8'($random(seed));
				u_queue.put_byte(b);
				e.disp[8*k+:8] = b;
			end
		end
		if (form == 2 || form == 3 || form == 5) begin
			b = 8'($random(seed));
			u_queue.put_byte(b);
			e.imm = b;
		end
		expq.push_back(e);
	endtask : gen

	////////////////////////////////////////////////////////////////////
	// Result compared on its taking edge
	always @(posedge CLK_SYS) begin
		if (DEC_VALID === 1'b1 && DEC_READY === 1'b1) begin
			if (expq.size() == 0)
				chk(32'h1, 32'h0);
			else begin
				cur = expq.pop_front();
				chk(32'(DEC_OP), 32'(cur.op));
				chk(32'(DEC_CLOCKS), 32'(cur.clocks));
				chk(32'(DEC_UNDEF), 32'(cur.undef));
				if (cur.full === 1'b1) begin
					chk(32'(DEC_COUNT_SRC), 32'(cur.cnt));
					chk(32'({DEC_WIDE, DEC_REG_IS_DEST}), 32'({cur.wide, cur.dest}));
					chk(32'(DEC_MEM), 32'(cur.mem));
					chk(32'({DEC_REG_FIELD, DEC_RM_FIELD}), 32'(cur.rr));
					chk(DEC_DISP, cur.disp);
					chk(32'(DEC_IMM), 32'(cur.imm));
				end
			end
		end
	end

	// No byte taken while a result is held
	always @(negedge CLK_SYS) begin
		if (DEC_VALID === 1'b1)
			chk(32'(BYTE_READY), 32'h0);
		gap <= ($random(seed) & 3) == 0;
		stall <= ($random(seed) & 1) == 0;
	end

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		miscompares++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		SYS_RST = 1'b1;
		gap = 1'b0;
		stall = 1'b0;
		repeat (10) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		SYS_RST = 1'b0;
		chk(32'({DEC_VALID, BYTE_READY, DEC_OP}), 32'h1F);
		chk(32'({DEC_IMM, DEC_CLOCKS, DEC_UNDEF, DEC_COUNT_SRC, DEC_WIDE,
			DEC_REG_IS_DEST, DEC_MEM, DEC_REG_FIELD, DEC_RM_FIELD}), 32'h0);
		chk(DEC_DISP, 32'h0);
		for (i = 0; i < 8; i++)
			gen(0, {2'h3, 3'(i), 3'h1});
		for (i = 0; i < 8; i++)
			gen(2, {2'h1, 3'(i), 3'h4});
		for (i = 0; i < 8; i++)
			gen(1, {2'h2, 3'(i), 3'h2});
		for (i = 3; i < 7; i++)
			gen(i, 8'h05);
		gen(7, 8'hC8);
		gen(7, 8'h08);
		gen(8, 8'h00);
		gen(0, {2'h0, 3'h1, 3'h4});
		gen(1, {2'h0, 3'h0, 3'h4});
		repeat (80)
			gen(($random(seed) & 32'hFF) % 9, 8'($random(seed)));
		for (i = 0; i < 15000 && expq.size() > 0; i++)
			@(posedge CLK_SYS);
		@(negedge CLK_SYS);
		chk(32'(expq.size()), 32'h0);
		report_and_stop();
	end

endmodule : srd_decoder_tb

`default_nettype wire

// ==== tb/srd_queue_model.sv ====
// Purpose: Byte queue source and result sink facing the decoder
// Assumes: Bench loads bytes with put_byte, drives gap and stall
// Notes: Signals change at the falling edge only
`timescale 1ns/1ps
`default_nettype none

module srd_queue_model (
	input wire logic clk,
	input wire logic gap,
	input wire logic stall,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic dec_ready
);
	logic [7:0] q[$];
	logic taken;

	initial begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
		dec_ready = 1'b0;
		taken = 1'b0;
	end

	task put_byte(input logic [7:0] b);
		q.push_back(b);
	endtask : put_byte

	////////////////////////////////////////////////////////////////////
	// Byte leaves the queue on its taking edge
	always @(posedge clk) begin
		if (byte_valid && byte_ready) begin
			void'(q.pop_front());
			taken = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Offer held until taken; idle data line toggles
	always @(negedge clk) begin
		dec_ready = ~stall;
		if (byte_valid && !taken) begin
		end else if (q.size() > 0 && !gap) begin
			byte_valid = 1'b1;
			byte_data = q[0];
		end else begin
			byte_valid = 1'b0;
			byte_data = ~byte_data;
		end
		taken = 1'b0;
	end

endmodule : srd_queue_model

`default_nettype wire
